//--- rtl/ssu_pkg.sv
// Purpose: Constants and types for the subtract and signed-sum unit.
// Assumes: 32-bit data, 9-bit register addresses, 40 MHz core clock.
// Notes:   Instruction layout is opcode, effect, condition, dest, source.
//
// What this block does
// (RULE1) Magnitude difference: dest minus absolute source
// (RULE2) Magnitude difference flags: zero, unsigned borrow
// (RULE3) Signed difference: zero flag, signed underflow borrow
// (RULE4) Source is register or 9-bit literal
// (RULE5) Word: opcode, effect, condition, dest, source
// (RULE6) Every operation completes in four cycles
// (RULE7) Signed extended difference subtracts source plus borrow
// (RULE8) Signed extended null: prior null and zero
// (RULE9) Unsigned extended difference: source plus borrow, underflow
// (RULE10) Unsigned extended null: prior null and zero
// (RULE11) Caller chains low, middle, top word differences
// (RULE12) Carry-signed sum negates source when borrow set
// (RULE13) Inverted-carry sum negates source when borrow clear
// (RULE14) Inverted-null sum negates source when null clear
// (RULE15) Sums: zero null flag, signed overflow borrow
// (RULE16) Flags change only with their write effect
// (RULE17) Result written unless suppress-result effect given
// (RULE18) Immediate bit selects zero-extended 9-bit literal
package ssu_pkg;
  localparam int DATA_W = 32;        // Data path width
  localparam int ADDR_W = 9;         // Register address width
  localparam int OPC_W  = 6;         // Opcode width
  localparam int INSN_W = 32;        // Instruction width

  // Field positions, counted from bit 0
  localparam int SRC_LSB  = 0;
  localparam int DST_LSB  = 9;
  localparam int COND_LSB = 18;
  localparam int EFF_LSB  = 22;
  localparam int OPC_LSB  = 26;

  // Effect field bit positions (null, borrow, result, immediate)
  localparam int EFF_IMM  = 0;
  localparam int EFF_RES  = 1;
  localparam int EFF_WBOR = 2;
  localparam int EFF_WNUL = 3;

  localparam logic [3:0] COND_ALWAYS = 4'hF;  // Unconditional execution

  // Timing: four cycles per instruction at 25 ns period
  localparam int CLK_PERIOD_NS = 25;
  localparam int OP_TIME_NS    = 100;
  localparam int OP_CYCLES     = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] LAST_PHASE = 2'(OP_CYCLES - 1);

  // Opcodes of the group
  typedef enum logic [5:0] {
    SSU_MAG_DIFF  = 6'h23,   // magnitude_difference_op
    SSU_CSUM      = 6'h24,   // carry_signed_add_op
    SSU_NCSUM     = 6'h25,   // inverted_carry_signed_add_op
    SSU_NZSUM     = 6'h27,   // inverted_null_signed_add_op
    SSU_UX_DIFF   = 6'h33,   // unsigned_extended_difference_op
    SSU_S_DIFF    = 6'h35,   // signed_difference_op
    SSU_SX_DIFF   = 6'h37    // signed_extended_difference_op
  } ssu_opc_t;

  // Sequencer states
  typedef enum logic [1:0] {
    SSU_IDLE  = 2'b00,
    SSU_FETCH = 2'b01,
    SSU_EXEC  = 2'b10
  } ssu_state_t;
endpackage : ssu_pkg

//--- rtl/ssu_alu.sv
// Purpose: Combinational arithmetic core of the subtract and signed-sum unit.
// Assumes: Operands already selected; flags are the values before the op.
// Notes:   Extended ops fold the borrow in as a 33-bit subtraction.
`timescale 1ns/10ps
module ssu_alu
  import ssu_pkg::*;
(
  // Operation and operands
  input  wire logic [OPC_W-1:0]  i_opc,
  input  wire logic [DATA_W-1:0] i_dst,
  input  wire logic [DATA_W-1:0] i_src,
  input  wire logic              i_null,
  input  wire logic              i_borrow,
  // Results
  output logic [DATA_W-1:0]      o_res,
  output logic                   o_null,
  output logic                   o_borrow,
  output logic                   o_valid_op
);
  ////////////////////////////////////////////////////////////////////////
  // Operand shaping
  wire logic              src_neg   = i_src[DATA_W-1];
  wire logic [DATA_W-1:0] src_abs   = src_neg ? DATA_W'(-i_src) : i_src;   // RULE1
  wire logic              cin       = i_borrow;
  wire logic [DATA_W:0]   mag_diff  = {1'b0, i_dst} - {1'b0, src_abs};     // RULE1
  wire logic [DATA_W:0]   ext_diff  = {1'b0, i_dst} - {1'b0, i_src} - {{DATA_W{1'b0}}, cin};
  wire logic [DATA_W-1:0] s_diff    = i_dst - i_src;
  // Signed underflow: operands of unlike sign and result sign differs from dest
  wire logic              s_unf     = (i_dst[DATA_W-1] ^ i_src[DATA_W-1]) &
                                      (s_diff[DATA_W-1] ^ i_dst[DATA_W-1]);  // RULE3
  wire logic              sx_unf    = (i_dst[DATA_W-1] ^ i_src[DATA_W-1]) &
                                      (ext_diff[DATA_W-1] ^ i_dst[DATA_W-1]); // RULE7

  // Sign choice for the three conditional sums
  wire logic negate = (i_opc == SSU_CSUM)  ?  i_borrow :   // RULE12
                      (i_opc == SSU_NCSUM) ? ~i_borrow :   // RULE13
                                             ~i_null;      // RULE14
  wire logic [DATA_W-1:0] sum_src = negate ? DATA_W'(-i_src) : i_src;
  wire logic [DATA_W-1:0] sum     = i_dst + sum_src;
  // Overflow judged on the summed operands; negating the most negative value keeps its sign
  wire logic sum_ovf = ~(i_dst[DATA_W-1] ^ sum_src[DATA_W-1]) &
                       (sum[DATA_W-1] ^ i_dst[DATA_W-1]);   // RULE15

  ////////////////////////////////////////////////////////////////////////
  // Result and flag selection
  always_comb begin
    o_res      = '0;
    o_null     = i_null;
    o_borrow   = i_borrow;
    o_valid_op = 1'b1;
    case (i_opc)
      SSU_MAG_DIFF: begin
        o_res    = mag_diff[DATA_W-1:0];
        o_null   = (mag_diff[DATA_W-1:0] == '0);            // RULE2
        o_borrow = mag_diff[DATA_W];                        // RULE2
      end
      SSU_S_DIFF: begin
        o_res    = s_diff;
        o_null   = (s_diff == '0);                          // RULE3
        o_borrow = s_unf;                                   // RULE3
      end
      SSU_SX_DIFF: begin
        o_res    = ext_diff[DATA_W-1:0];
        o_null   = i_null & (ext_diff[DATA_W-1:0] == '0);   // RULE8
        o_borrow = sx_unf;                                  // RULE7
      end
      SSU_UX_DIFF: begin
        o_res    = ext_diff[DATA_W-1:0];
        o_null   = i_null & (ext_diff[DATA_W-1:0] == '0);   // RULE10
        o_borrow = ext_diff[DATA_W];                        // RULE9
      end
      SSU_CSUM, SSU_NCSUM, SSU_NZSUM: begin
        o_res    = sum;
        o_null   = (sum == '0);                             // RULE15
        o_borrow = sum_ovf;                                 // RULE15
      end
      default: begin
        o_valid_op = 1'b0;
      end
    endcase
  end
endmodule : ssu_alu

//--- rtl/ssu_unit.sv
// Purpose: Four-cycle execution unit for the subtract and signed-sum group.
// Assumes: Register file answers a read in the same cycle as its address.
// Notes:   Multi-word chains rely on the caller ordering the words.
`timescale 1ns/10ps
module ssu_unit
  import ssu_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // Instruction issue
  input  wire logic              i_issue,
  input  wire logic [INSN_W-1:0] i_insn,
  output logic                   o_busy,
  output logic                   o_done,
  output logic                   o_illegal,
  // Register file read ports
  output logic [ADDR_W-1:0]      o_rd_dst_addr,
  output logic [ADDR_W-1:0]      o_rd_src_addr,
  input  wire logic [DATA_W-1:0] i_rd_dst_data,
  input  wire logic [DATA_W-1:0] i_rd_src_data,
  // Register file write port
  output logic                   o_wr_en,
  output logic [ADDR_W-1:0]      o_wr_addr,
  output logic [DATA_W-1:0]      o_wr_data,
  // Flags
  output logic                   o_null_flag,
  output logic                   o_borrow_flag
);
  ////////////////////////////////////////////////////////////////////////
  // State
  ssu_state_t        state_reg,  state_next;
  logic [1:0]        phase_reg,  phase_next;    // Cycle within the op
  logic [INSN_W-1:0] insn_reg,   insn_next;     // Latched instruction
  logic [DATA_W-1:0] dst_reg,    dst_next;      // Captured dest operand
  logic [DATA_W-1:0] src_reg,    src_next;      // Captured source operand
  logic              null_reg,   null_next;     // Null flag
  logic              bor_reg,    bor_next;      // Borrow flag
  logic              wr_en_reg,  wr_en_next;    // Write-back strobe
  logic [DATA_W-1:0] wr_data_reg, wr_data_next; // Write-back data
  logic              done_reg,   done_next;     // Completion pulse
  logic              ill_reg,    ill_next;      // Illegal opcode pulse

  ////////////////////////////////////////////////////////////////////////
  // Instruction field decode
  wire logic [OPC_W-1:0]  f_opc  = insn_reg[OPC_LSB +: OPC_W];     // RULE5
  wire logic [3:0]        f_eff  = insn_reg[EFF_LSB +: 4];         // RULE5
  wire logic [3:0]        f_cond = insn_reg[COND_LSB +: 4];        // RULE5
  wire logic [ADDR_W-1:0] f_dst  = insn_reg[DST_LSB +: ADDR_W];    // RULE5
  wire logic [ADDR_W-1:0] f_src  = insn_reg[SRC_LSB +: ADDR_W];    // RULE5
  wire logic write_null_flag_effect   = f_eff[EFF_WNUL];
  wire logic write_borrow_flag_effect = f_eff[EFF_WBOR];
  wire logic suppress_result_write    = ~f_eff[EFF_RES];
  wire logic imm_sel                  = f_eff[EFF_IMM];
  // Other condition codes are never executed by this unit; they retire silently
  wire logic cond_ok = (f_cond == COND_ALWAYS);

  // Immediate takes the zero-extended literal in place of the register
  wire logic [DATA_W-1:0] src_sel = imm_sel ? {{(DATA_W-ADDR_W){1'b0}}, f_src}
                                            : i_rd_src_data;    // RULE4 RULE18

  ////////////////////////////////////////////////////////////////////////
  // Arithmetic core
  logic [DATA_W-1:0] alu_res;
  logic              alu_null;
  logic              alu_bor;
  logic              alu_valid;

  ssu_alu u_alu (
    .i_opc      (f_opc),
    .i_dst      (dst_reg),
    .i_src      (src_reg),
    .i_null     (null_reg),
    .i_borrow   (bor_reg),
    .o_res      (alu_res),
    .o_null     (alu_null),
    .o_borrow   (alu_bor),
    .o_valid_op (alu_valid)
  );

  wire logic commit   = (state_reg == SSU_EXEC) && (phase_reg == LAST_PHASE);
  wire logic exec_ok  = commit && cond_ok && alu_valid;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_next   = state_reg;
    phase_next   = phase_reg;
    insn_next    = insn_reg;
    dst_next     = dst_reg;
    src_next     = src_reg;
    null_next    = null_reg;
    bor_next     = bor_reg;
    wr_en_next   = 1'b0;
    wr_data_next = wr_data_reg;
    done_next    = 1'b0;
    ill_next     = 1'b0;
    case (state_reg)
      SSU_IDLE: begin
        // Accept a new instruction; phase 0 is the issue cycle
        if (i_issue) begin
          insn_next  = i_insn;
          phase_next = 2'd1;
          state_next = SSU_FETCH;
        end
      end
      SSU_FETCH: begin
        // Register file data is valid now; capture both operands
        dst_next   = i_rd_dst_data;
        src_next   = src_sel;
        phase_next = phase_reg + 2'd1;
        state_next = SSU_EXEC;
      end
      SSU_EXEC: begin
        if (commit) begin
          // Whole op spans issue through commit: four cycles
          state_next = SSU_IDLE;                                  // RULE6
          phase_next = 2'd0;
          done_next  = 1'b1;
          ill_next   = cond_ok && !alu_valid;
          if (exec_ok && write_null_flag_effect) begin
            null_next = alu_null;                                 // RULE16
          end
          if (exec_ok && write_borrow_flag_effect) begin
            bor_next  = alu_bor;                                  // RULE16
          end
          wr_en_next   = exec_ok && !suppress_result_write;       // RULE17
          wr_data_next = alu_res;
        end else begin
          phase_next = phase_reg + 2'd1;
        end
      end
      default: begin
        state_next = SSU_IDLE;
        phase_next = 2'd0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg   <= SSU_IDLE;
      phase_reg   <= 2'd0;
      insn_reg    <= '0;
      dst_reg     <= '0;
      src_reg     <= '0;
      null_reg    <= 1'b0;
      bor_reg     <= 1'b0;
      wr_en_reg   <= 1'b0;
      wr_data_reg <= '0;
      done_reg    <= 1'b0;
      ill_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      phase_reg   <= phase_next;
      insn_reg    <= insn_next;
      dst_reg     <= dst_next;
      src_reg     <= src_next;
      null_reg    <= null_next;
      bor_reg     <= bor_next;
      wr_en_reg   <= wr_en_next;
      wr_data_reg <= wr_data_next;
      done_reg    <= done_next;
      ill_reg     <= ill_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_busy        = (state_reg != SSU_IDLE);
  assign o_done        = done_reg;
  assign o_illegal     = ill_reg;
  assign o_rd_dst_addr = f_dst;
  assign o_rd_src_addr = f_src;
  assign o_wr_en       = wr_en_reg;
  assign o_wr_addr     = f_dst;
  assign o_wr_data     = wr_data_reg;
  assign o_null_flag   = null_reg;
  assign o_borrow_flag = bor_reg;
endmodule : ssu_unit

//--- tb/ssu_rf_model.sv
// Purpose: Register file model facing the subtract and signed-sum unit.
// Assumes: Reads are combinational, writes land on the rising edge.
// Notes:   A preload port lets the bench seed registers between operations.
`timescale 1ns/10ps
module ssu_rf_model
  import ssu_pkg::*;
(
  // Clock
  input  wire logic              i_clk_sys,
  // Read side
  input  wire logic [ADDR_W-1:0] i_rd_dst_addr,
  input  wire logic [ADDR_W-1:0] i_rd_src_addr,
  output logic [DATA_W-1:0]      o_rd_dst_data,
  output logic [DATA_W-1:0]      o_rd_src_data,
  // Write side from the unit, then bench preload
  input  wire logic              i_wr_en,
  input  wire logic [ADDR_W-1:0] i_wr_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic              i_ld_en,
  input  wire logic [ADDR_W-1:0] i_ld_addr,
  input  wire logic [DATA_W-1:0] i_ld_data
);
  logic [DATA_W-1:0] mem [2**ADDR_W];  // Register storage, unseeded words stay unknown
  // Data stands as long as the address does, so either read timing works
  assign o_rd_dst_data = mem[i_rd_dst_addr];
  assign o_rd_src_data = mem[i_rd_src_addr];
  // Unit write wins; the bench never preloads in a commit cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end else if (i_ld_en) begin
      mem[i_ld_addr] <= i_ld_data;
    end
  end
endmodule : ssu_rf_model

//--- tb/ssu_unit_chk.sv
// Purpose: Port-level timing and effect checks for the unit.
// Assumes: The retiring word is the one issued four edges earlier.
// Notes:   Attached to every unit instance by bind.
`timescale 1ns/10ps
module ssu_unit_chk
  import ssu_pkg::*;
(
  // Clock and reset
  input wire logic              i_clk_sys,
  input wire logic              i_rst,
  // Issue and status
  input wire logic              i_issue,
  input wire logic [INSN_W-1:0] i_insn,
  input wire logic              o_busy,
  input wire logic              o_done,
  input wire logic              o_illegal,
  // Write-back and flags
  input wire logic              o_wr_en,
  input wire logic [ADDR_W-1:0] o_wr_addr,
  input wire logic              o_null_flag,
  input wire logic              o_borrow_flag
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////
  property p_span; i_issue && !o_busy |=> o_busy [*3] ##1 (o_done && !o_busy); endproperty
  property p_addr; o_wr_en |-> o_wr_addr == $past(i_insn[DST_LSB+:ADDR_W], 4); endproperty
  property p_nr; o_done && !$past(i_insn[EFF_LSB+EFF_RES], 4) |-> !o_wr_en; endproperty
  property p_cond;
    o_done && $past(i_insn[COND_LSB+:4], 4) != COND_ALWAYS |->
      !o_wr_en && !o_illegal && $stable(o_null_flag) && $stable(o_borrow_flag);
  endproperty
  property p_wnul; o_done && !$past(i_insn[EFF_LSB+EFF_WNUL], 4) |-> $stable(o_null_flag); endproperty
  property p_wbor; o_done && !$past(i_insn[EFF_LSB+EFF_WBOR], 4) |-> $stable(o_borrow_flag); endproperty
  // Flags may only move in a retire cycle
  property p_quiet; !o_done |-> $stable(o_null_flag) && $stable(o_borrow_flag); endproperty
  property p_ill; o_illegal |-> o_done && !o_wr_en; endproperty
  a_span: assert property (p_span) else $error("busy or done timing wrong");
  a_addr: assert property (p_addr) else $error("write address not the issued dest");
  a_nr: assert property (p_nr) else $error("write despite suppressed result");
  a_cond: assert property (p_cond) else $error("skipped word had an effect");
  a_wnul: assert property (p_wnul) else $error("null flag moved without its effect");
  a_wbor: assert property (p_wbor) else $error("borrow flag moved without its effect");
  a_quiet: assert property (p_quiet) else $error("flag moved outside a retire cycle");
  a_ill: assert property (p_ill) else $error("illegal word wrote back");
  c_wr: cover property (o_wr_en);
  c_ill: cover property (o_illegal);
  c_skip: cover property (o_done && !o_wr_en && !o_illegal);
endmodule : ssu_unit_chk
bind ssu_unit ssu_unit_chk u_chk (.i_clk_sys, .i_rst, .i_issue, .i_insn, .o_busy, .o_done, .o_illegal,
  .o_wr_en, .o_wr_addr, .o_null_flag, .o_borrow_flag);

//--- tb/test_subtract_and_signed_sum_unit.sv
// Purpose: Self-checking bench for the subtract and signed-sum unit.
// Assumes: Register file model answers reads at once.
// Notes:   Expected values come from a bench-side arithmetic model.
`timescale 1ns/10ps
module test_subtract_and_signed_sum_unit;
  import ssu_pkg::*;
  logic              i_clk_sys, i_rst, i_issue;         // Unit inputs
  logic [INSN_W-1:0] i_insn;
  logic              o_busy, o_done, o_illegal, o_wr_en;
  logic              o_null_flag, o_borrow_flag;
  logic [ADDR_W-1:0] o_rd_dst_addr, o_rd_src_addr, o_wr_addr, ld_addr;
  logic [DATA_W-1:0] i_rd_dst_data, i_rd_src_data, o_wr_data, ld_data;
  logic              ld_en, ez, ec;                     // Preload strobe, expected flags
  int                fail_count, n_compared, cycles;
  ssu_opc_t          ops [7];                           // Every opcode of the group
  ssu_unit i_dut (.i_clk_sys, .i_rst, .i_issue, .i_insn, .o_busy, .o_done, .o_illegal,
    .o_rd_dst_addr, .o_rd_src_addr, .i_rd_dst_data, .i_rd_src_data, .o_wr_en, .o_wr_addr,
    .o_wr_data, .o_null_flag, .o_borrow_flag);
  ssu_rf_model i_rf (.i_clk_sys, .i_rd_dst_addr(o_rd_dst_addr), .i_rd_src_addr(o_rd_src_addr),
    .o_rd_dst_data(i_rd_dst_data), .o_rd_src_data(i_rd_src_data), .i_wr_en(o_wr_en),
    .i_wr_addr(o_wr_addr), .i_wr_data(o_wr_data), .i_ld_en(ld_en), .i_ld_addr(ld_addr), .i_ld_data(ld_data));
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // Ceiling far above the roughly 930 cycles the run needs
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic load(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    ld_addr = a;
    ld_data = v;
    ld_en = 1'b1;
    @(posedge i_clk_sys);
    #2;
    ld_en = 1'b0;
  endtask : load
  // Result in [31:0], borrow in [32], null in [33]
  function automatic logic [33:0] model(input logic [5:0] op, input logic [31:0] d, input logic [31:0] s,
                                        input logic z, input logic c);
    logic [32:0] w;
    logic [31:0] n;
    logic        ext, cb;
    n = s;
    if (op == SSU_MAG_DIFF) n = s[31] ? -s : s;
    if (op == SSU_CSUM) n = c ? -s : s;
    if (op == SSU_NCSUM) n = c ? s : -s;
    if (op == SSU_NZSUM) n = z ? s : -s;
    ext = op == SSU_UX_DIFF || op == SSU_SX_DIFF;
    if (op[4]) w = {1'b0, d} - {1'b0, s} - 33'(ext & c);
    else if (op == SSU_MAG_DIFF) w = {1'b0, d} - {1'b0, n};
    else w = {1'b0, d} + {1'b0, n};
    if (op == SSU_MAG_DIFF || op == SSU_UX_DIFF) cb = w[32];
    else if (op[4]) cb = d[31] != s[31] && w[31] != d[31];
    else cb = d[31] == n[31] && w[31] != d[31];
    return {(w[31:0] == 32'h0) & (z | !ext), cb, w[31:0]};
  endfunction : model
  // One full instruction: seed registers, issue, judge the retire cycle
  task automatic run(input logic [5:0] op, input logic [3:0] eff, input logic [3:0] cond,
                     input logic [ADDR_W-1:0] sa, input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] s);
    logic [33:0] e;
    logic        ok;
    int          n;
    load(9'h010, d);
    load(sa, s);
    e = model(op, d, eff[EFF_IMM] ? 32'(sa) : s, ez, ec);
    ok = cond == COND_ALWAYS && op inside {SSU_MAG_DIFF, SSU_CSUM, SSU_NCSUM, SSU_NZSUM,
                                            SSU_UX_DIFF, SSU_S_DIFF, SSU_SX_DIFF};
    i_insn = {op, eff, cond, 9'h010, sa};
    i_issue = 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      #2;
      i_issue = 1'b0;
      n++;
    end while (o_done !== 1'b1 && n < 20);
    check(32'(n), 32'h4);
    check(32'({o_busy, o_wr_addr, o_rd_dst_addr, o_rd_src_addr}), 32'({1'b0, 9'h010, 9'h010, sa}));
    check(32'(o_illegal), 32'(cond == COND_ALWAYS && !ok));
    check(32'(o_wr_en), 32'(ok && eff[EFF_RES]));
    if (ok && eff[EFF_RES]) check(o_wr_data, e[31:0]);
    if (ok && eff[EFF_WNUL]) ez = e[33];
    if (ok && eff[EFF_WBOR]) ec = e[32];
    check(32'({o_null_flag, o_borrow_flag}), 32'({ez, ec}));
    @(posedge i_clk_sys);
    #2;
  endtask : run
  // Zero difference gives null set, borrow clear; signed underflow the reverse
  task automatic preset(input logic zc);
    if (zc) run(SSU_S_DIFF, 4'hE, COND_ALWAYS, 9'h020, 32'h8000_0000, 32'h1);
    else run(SSU_S_DIFF, 4'hE, COND_ALWAYS, 9'h020, 32'h3, 32'h3);
  endtask : preset
  ////////////////////////////////////////////////////////////////
  task automatic t_ops();
    logic [DATA_W-1:0] dv [4] = '{32'h5, 32'h8000_0000, 32'h7FFF_FFFF, 32'h3};
    logic [DATA_W-1:0] sv [4] = '{32'h7, 32'h1, 32'hFFFF_FFFF, 32'h3};
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 7; k++) begin
        for (int j = 0; j < 4; j++) begin
          preset(p[0]);
          run(ops[k], 4'hE, COND_ALWAYS, 9'h020, dv[j], sv[j]);
        end
      end
    end
  endtask : t_ops
  // No effect, then result, null and borrow effect bits alone, flags preset so any change shows
  task automatic t_eff();
    logic [3:0] ef [4] = '{4'h0, 4'h2, 4'h8, 4'h4};
    for (int k = 0; k < 4; k++) begin
      preset(1'b0);
      run(SSU_S_DIFF, ef[k], COND_ALWAYS, 9'h020, 32'h8000_0000, 32'h1);
    end
  endtask : t_eff
  // Skipped condition, unknown opcode, then literal source over a seeded register
  task automatic t_misc();
    preset(1'b1);
    run(SSU_CSUM, 4'hE, 4'h0, 9'h020, 32'h5, 32'h5);
    run(6'h3F, 4'hE, COND_ALWAYS, 9'h020, 32'h5, 32'h6);
    run(SSU_S_DIFF, 4'hF, COND_ALWAYS, 9'h1FF, 32'h1000, 32'hDEAD_0000);
  endtask : t_misc
  // Two-word chains: one with a non-zero low word, one all zero
  task automatic t_chain();
    preset(1'b0);
    run(SSU_UX_DIFF, 4'hE, COND_ALWAYS, 9'h020, 32'h0, 32'h1);
    run(SSU_SX_DIFF, 4'hE, COND_ALWAYS, 9'h020, 32'h1, 32'h0);
    preset(1'b0);
    run(SSU_UX_DIFF, 4'hE, COND_ALWAYS, 9'h020, 32'h5, 32'h5);
    run(SSU_SX_DIFF, 4'hE, COND_ALWAYS, 9'h020, 32'h7, 32'h7);
  endtask : t_chain
  initial begin
    i_rst = 1'b1;
    i_issue = 1'b0;
    i_insn = '0;
    ld_en = 1'b0;
    ld_addr = '0;
    ld_data = '0;
    ez = 1'b0;
    ec = 1'b0;
    ops = '{SSU_MAG_DIFF, SSU_CSUM, SSU_NCSUM, SSU_NZSUM, SSU_UX_DIFF, SSU_S_DIFF, SSU_SX_DIFF};
    repeat (16) @(posedge i_clk_sys);
    #2;
    i_rst = 1'b0;
    check(32'({o_busy, o_done, o_wr_en, o_null_flag, o_borrow_flag}), 32'h0);
    t_ops();
    t_eff();
    t_misc();
    t_chain();
    end_sim();
  end
endmodule : test_subtract_and_signed_sum_unit
